// *** core/rmx_defs.svh ***
`ifndef RMX_DEFS_SVH
`define RMX_DEFS_SVH
`define RMX_BANK_SIZE 10
`define RMX_BANK_B_FIRST 7'h0a
`define RMX_LAST_BANK_CH 7'h13
`define RMX_CH_SENSE_A 7'h5b
`define RMX_CH_SENSE_B 7'h5c
`define RMX_CH_SOURCE_A 7'h5d
`define RMX_CH_SOURCE_B 7'h5e
`define RMX_BANK_RESET 10'h000
`define RMX_TREE_RESET 4'h0
`define RMX_SYNC_STAGES 3
`endif

// *** core/rmx_pkg.sv ***
package rmx_pkg;
   typedef logic [6:0] rmx_chan_t;
   typedef logic [9:0] rmx_bank_t;
   typedef enum logic [3:0] {
      RMX_NONE = 4'h1,
      RMX_BANK = 4'h2,
      RMX_TREE = 4'h4,
      RMX_BAD = 4'h8
   } rmx_kind_t;
endpackage : rmx_pkg

// *** core/rmx_pin_sync.sv ***
`timescale 1ns/10ps
`include "rmx_defs.svh"
module rmx_pin_sync (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o
);
   logic [`RMX_SYNC_STAGES-1:0] stage;
   logic [`RMX_SYNC_STAGES-1:0] next_stage;
   logic next_level;

   // three sync flops and a level flop; the level only moves once stages two and three agree
   always_comb begin
      next_stage = {stage[`RMX_SYNC_STAGES-2:0], pin_i};
      next_level = level_o;
      if (stage[1] == stage[2]) begin
         next_level = stage[2];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage <= '0;
         level_o <= 1'b0;
      end else begin
         stage <= next_stage;
         level_o <= next_level;
      end
   end
endmodule : rmx_pin_sync

// *** core/rmx_relay_select.sv ***
`timescale 1ns/10ps
`include "rmx_defs.svh"
module rmx_relay_select (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_close_i,
   input wire rmx_pkg::rmx_chan_t cmd_chan_i,
   input wire logic backplane_isolation_link_i,
   output rmx_pkg::rmx_bank_t bank_a_high_o,
   output rmx_pkg::rmx_bank_t bank_a_low_o,
   output rmx_pkg::rmx_bank_t bank_a_guard_o,
   output rmx_pkg::rmx_bank_t bank_b_high_o,
   output rmx_pkg::rmx_bank_t bank_b_low_o,
   output rmx_pkg::rmx_bank_t bank_b_guard_o,
   output logic [3:0] tree_high_o,
   output logic [3:0] tree_low_o,
   output logic [3:0] tree_guard_o,
   output logic [3:0] tree_state_o,
   output logic sense_path_a_o,
   output logic sense_path_b_o,
   output logic source_pair_a_o,
   output logic source_pair_b_o,
   output logic cmd_error_o
);
   import rmx_pkg::*;

   logic rst_meta;
   logic rst_n;
   logic isolate_position;
   rmx_kind_t kind;
   rmx_bank_t bank_a;
   rmx_bank_t bank_b;
   rmx_bank_t next_bank_a;
   rmx_bank_t next_bank_b;
   logic [3:0] tree;
   logic [3:0] next_tree;
   logic [3:0] tree_drv;
   logic [3:0] next_tree_drv;
   logic next_error;
   logic cmd_error;
   rmx_bank_t onehot;
   logic [6:0] offset;
   logic [3:0] paths;
   logic [3:0] next_paths;

   // reset release through two flops so every flop leaves reset together
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // jumper is a strap pin; high means the isolate position is fitted
   rmx_pin_sync u_iso_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .pin_i(backplane_isolation_link_i),
      .level_o(isolate_position)
   );

   // classify the channel number of the command
   always_comb begin
      kind = RMX_BAD;
      offset = 7'h00;
      if (!cmd_valid_i) begin
         kind = RMX_NONE;
      end else if (cmd_chan_i < `RMX_BANK_B_FIRST) begin
         kind = RMX_BANK;
         offset = cmd_chan_i;
      end else if (cmd_chan_i <= `RMX_LAST_BANK_CH) begin
         kind = RMX_BANK;
         offset = 7'(cmd_chan_i - `RMX_BANK_B_FIRST);
      end else if (cmd_chan_i >= `RMX_CH_SENSE_A && cmd_chan_i <= `RMX_CH_SOURCE_B) begin
         kind = RMX_TREE;
      end
      onehot = rmx_bank_t'(1) << offset[3:0];
   end

   // bank group; a close replaces the bank's prior channel, an open clears one bit
   always_comb begin
      next_bank_a = bank_a;
      next_bank_b = bank_b;
      case (kind)
         RMX_BANK: begin
            if (cmd_chan_i < `RMX_BANK_B_FIRST) begin
               if (cmd_close_i) begin
                  next_bank_a = onehot;
               end else begin
                  next_bank_a = bank_a & ~onehot;
               end
            end else begin
               if (cmd_close_i) begin
                  next_bank_b = onehot;
               end else begin
                  next_bank_b = bank_b & ~onehot;
               end
            end
         end
         default: begin
            // tree, bad and idle commands leave the banks alone
            next_bank_a = bank_a;
            next_bank_b = bank_b;
         end
      endcase
   end

   // limitation: old and new channel swap on one edge; any break gap
   // between them is up to the coil drivers outside this block
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bank_a <= `RMX_BANK_RESET;
         bank_b <= `RMX_BANK_RESET;
      end else begin
         bank_a <= next_bank_a;
         bank_b <= next_bank_b;
      end
   end

   // tree group; bits 0 sense a, 1 sense b, 2 source a, 3 source b
   always_comb begin
      next_tree = tree;
      case (kind)
         RMX_TREE: begin
            if (cmd_chan_i == `RMX_CH_SENSE_A) begin
               next_tree[0] = cmd_close_i;
               if (cmd_close_i) begin
                  next_tree[1] = 1'b0;
               end
            end else if (cmd_chan_i == `RMX_CH_SENSE_B) begin
               next_tree[1] = cmd_close_i;
               if (cmd_close_i) begin
                  next_tree[0] = 1'b0;
               end
            end else if (cmd_chan_i == `RMX_CH_SOURCE_A) begin
               next_tree[2] = cmd_close_i;
               if (cmd_close_i) begin
                  next_tree[3] = 1'b0;
               end
            end else begin
               next_tree[3] = cmd_close_i;
               if (cmd_close_i) begin
                  next_tree[2] = 1'b0;
               end
            end
         end
         default: begin
            next_tree = tree;
         end
      endcase
      // the jumper is mechanical, so it gates the drive, not the stored state
      next_tree_drv = isolate_position ? 4'h0 : next_tree;
   end

   // state and drive register together, so a jumper move never loses a close
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tree <= `RMX_TREE_RESET;
         tree_drv <= `RMX_TREE_RESET;
      end else begin
         tree <= next_tree;
         tree_drv <= next_tree_drv;
      end
   end

   // error group; one pulse per refused command, relays left as they were
   always_comb begin
      next_error = 1'b0;
      case (kind)
         RMX_BAD: begin
            next_error = 1'b1;
         end
         default: begin
            next_error = 1'b0;
         end
      endcase
   end

   // error pulse register
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd_error <= 1'b0;
      end else begin
         cmd_error <= next_error;
      end
   end

   // a bank reaches the backplane only through its own closed tree switch;
   // built from next values so the flags move on the same edge as the relays
   always_comb begin
      next_paths[0] = next_tree_drv[0] & (|next_bank_a);
      next_paths[1] = next_tree_drv[1] & (|next_bank_b);
      next_paths[2] = next_tree_drv[2] & (|next_bank_a);
      next_paths[3] = next_tree_drv[3] & (|next_bank_b);
   end

   // path flags are data outputs, so they get flops of their own
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         paths <= 4'h0;
      end else begin
         paths <= next_paths;
      end
   end

   // three poles per switch share one coil state
   assign bank_a_high_o = bank_a;
   assign bank_a_low_o = bank_a;
   assign bank_a_guard_o = bank_a;
   assign bank_b_high_o = bank_b;
   assign bank_b_low_o = bank_b;
   assign bank_b_guard_o = bank_b;
   assign tree_high_o = tree_drv;
   assign tree_low_o = tree_drv;
   assign tree_guard_o = tree_drv;
   assign tree_state_o = tree;
   assign cmd_error_o = cmd_error;

   // path flags come straight from their own flops
   assign sense_path_a_o = paths[0];
   assign sense_path_b_o = paths[1];
   assign source_pair_a_o = paths[2];
   assign source_pair_b_o = paths[3];
endmodule : rmx_relay_select

// *** verification/rmx_relay_select_sva.sv ***
`timescale 1ns/10ps
module rmx_relay_select_sva (
   input logic core_clk_i,
   input logic reset_n_i,
   input logic cmd_valid_i,
   input logic cmd_close_i,
   input rmx_pkg::rmx_chan_t cmd_chan_i,
   input logic backplane_isolation_link_i,
   input rmx_pkg::rmx_bank_t bank_a_high_o,
   input logic [3:0] tree_high_o,
   input logic [3:0] tree_guard_o,
   input logic [3:0] tree_state_o,
   input logic sense_path_a_o,
   input logic cmd_error_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // accepted close aimed at channels lo..hi
   sequence close_in(lo, hi);
      cmd_valid_i && cmd_close_i && cmd_chan_i >= lo && cmd_chan_i <= hi;
   endsequence
   chk_bank_one_hot: assert property (close_in(7'h00, 7'h09) |=>
      bank_a_high_o == 10'h001 << $past(cmd_chan_i)) else $error("bank select");
   chk_tree_decode: assert property (close_in(7'h5b, 7'h5e) |=>
      tree_state_o[$past(cmd_chan_i) - 7'h5b]) else $error("tree select");
   chk_tree_exclusive: assert property (!(tree_state_o[0] && tree_state_o[1]) &&
      !(tree_state_o[2] && tree_state_o[3])) else $error("two trees of a type");
   chk_poles_track: assert property (tree_guard_o == tree_high_o &&
      (tree_high_o & ~tree_state_o) == 4'h0) else $error("poles differ");
   chk_sense_route: assert property (
      sense_path_a_o == (tree_high_o[0] && |bank_a_high_o)) else $error("sense path");
   chk_isolate_cut: assert property (backplane_isolation_link_i [*6] |->
      tree_high_o == 4'h0) else $error("isolated tree driven");
   chk_bad_channel: assert property (cmd_valid_i && cmd_chan_i > 7'h13 &&
      !(cmd_chan_i inside {[7'h5b:7'h5e]}) |=> cmd_error_o && $stable(bank_a_high_o))
      else $error("bad channel");
   chk_reset_open: assert property ($rose(reset_n_i) |->
      bank_a_high_o == 10'h000 && tree_state_o == 4'h0) else $error("closed at reset");
endmodule : rmx_relay_select_sva
bind rmx_relay_select rmx_relay_select_sva rmx_relay_select_sva_inst (.*);

// *** verification/rmx_ctrl_model.sv ***
`timescale 1ns/10ps
module rmx_ctrl_model (
   input logic core_clk_i,
   output logic cmd_valid_o,
   output logic cmd_close_o,
   output rmx_pkg::rmx_chan_t cmd_chan_o
);
   initial {cmd_valid_o, cmd_close_o, cmd_chan_o} = '0;
   // a held strobe repeats the command, so drop it after one edge
   task automatic send(input logic c, input rmx_pkg::rmx_chan_t ch);
      cmd_valid_o <= 1'b1;
      cmd_close_o <= c;
      cmd_chan_o <= ch;
      @(posedge core_clk_i);
      cmd_valid_o <= 1'b0;
      cmd_chan_o <= ~ch; // idle lines never keep the old channel
   endtask : send
endmodule : rmx_ctrl_model

// *** verification/rmx_relay_select_bench.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch %0t %h %h", $time, a, e); end end
module rmx_relay_select_bench;
   logic core_clk_i, reset_n_i, cmd_valid_i, cmd_close_i, backplane_isolation_link_i, exp_err;
   logic sense_path_a_o, sense_path_b_o, source_pair_a_o, source_pair_b_o, cmd_error_o;
   logic [3:0] tree_high_o, tree_low_o, tree_guard_o, tree_state_o, exp_tree, td, paths;
   rmx_pkg::rmx_bank_t bank_a_high_o, bank_a_low_o, bank_a_guard_o, exp_a;
   rmx_pkg::rmx_bank_t bank_b_high_o, bank_b_low_o, bank_b_guard_o, exp_b;
   rmx_pkg::rmx_chan_t cmd_chan_i;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 18;
   logic [7:0] r;
   // edges of each bank, a four-wire pair, bad channels, then two opens
   rmx_pkg::rmx_chan_t corner[14] = '{7'h09, 7'h00, 7'h13, 7'h0a, 7'h5c, 7'h5b, 7'h5d,
      7'h5e, 7'h14, 7'h5a, 7'h5f, 7'h7f, 7'h00, 7'h5d};
   rmx_relay_select rmx_relay_select_inst (.*);
   rmx_ctrl_model rmx_ctrl_model_inst (.core_clk_i, .cmd_valid_o(cmd_valid_i),
      .cmd_close_o(cmd_close_i), .cmd_chan_o(cmd_chan_i));
   // reference outcome of one command
   function automatic void model(input logic c, input rmx_pkg::rmx_chan_t ch);
      logic [3:0] t;
      t = 4'h1 << (ch - 7'h5b);
      exp_err = 1'b0;
      if (ch <= 7'h09) exp_a = c ? 10'h001 << ch : exp_a & ~(10'h001 << ch);
      else if (ch <= 7'h13)
         exp_b = c ? 10'h001 << (ch - 7'h0a) : exp_b & ~(10'h001 << (ch - 7'h0a));
      else if (ch >= 7'h5b && ch <= 7'h5e)
         exp_tree = c ? exp_tree & ~{t[2], t[3], t[0], t[1]} | t : exp_tree & ~t;
      else exp_err = 1'b1;
   endfunction : model
   // iso masks the tree drive only, the stored state stays
   task automatic check_all(input logic iso);
      td = exp_tree & ~{4{iso}};
      paths = {source_pair_b_o, source_pair_a_o, sense_path_b_o, sense_path_a_o};
      `CHK({bank_a_high_o, bank_a_low_o, bank_a_guard_o}, {3{exp_a}})
      `CHK({bank_b_high_o, bank_b_low_o, bank_b_guard_o}, {3{exp_b}})
      `CHK(tree_state_o, exp_tree)
      `CHK({tree_high_o, tree_low_o, tree_guard_o}, {3{td}})
      `CHK(paths, td & {2{|exp_b, |exp_a}})
      `CHK(cmd_error_o, exp_err)
   endtask : check_all
   // entered at a rising edge; looks once the answer has landed
   task automatic issue(input logic c, input rmx_pkg::rmx_chan_t ch);
      rmx_ctrl_model_inst.send(c, ch);
      model(c, ch);
      @(negedge core_clk_i);
      check_all(1'b0);
      @(posedge core_clk_i);
   endtask : issue
   task automatic end_sim();
      $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   initial begin
      reset_n_i = 1'b0;
      backplane_isolation_link_i = 1'b0;
      {exp_a, exp_b, exp_tree, exp_err} = '0;
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      check_all(1'b0);
      $display("reset test done");
      @(posedge core_clk_i);
      foreach (corner[i]) issue(i < 12, corner[i]);
      $display("corner test done");
      repeat (300) begin
         r = 8'($random(seed));
         issue(r[7], r[6:0]);
      end
      $display("random test done");
      issue(1'b1, 7'h5b);
      backplane_isolation_link_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      @(negedge core_clk_i);
      check_all(1'b1);
      @(posedge core_clk_i);
      backplane_isolation_link_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      @(negedge core_clk_i);
      check_all(1'b0);
      $display("isolation test done");
      end_sim();
   end
endmodule : rmx_relay_select_bench
